// *** flash_guard_pkg.sv ***
package flash_guard_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing and geometry
   localparam int CLK_PERIOD_NS = 20;
   localparam int ADDR_W        = 13;
   localparam int LOCK_W        = 2;

   ////////////////////////////////////////////////////////////////////////////
   // lock pair encoding, a one means unprogrammed
   localparam logic [LOCK_W-1:0] LOCK_OPEN = 2'h3;
   localparam int LOCK_LOW  = 0;  // clear: erases and writes into the section refused
   localparam int LOCK_HIGH = 1;  // clear: loads across sections refused
   localparam logic [1:0] BOOT_SIZE_RST = 2'h0;
   localparam logic [1:0] BOOT_SIZE_TOP = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_LOCK     = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;

   localparam int CTRL_REEN     = 0;
   localparam int STAT_BUSY     = 0;
   localparam int STAT_HALT     = 1;
   localparam int STAT_OP       = 2;
   localparam int LOCK_APP_LSB  = 0;
   localparam int LOCK_BOOT_LSB = 2;
   localparam logic [3:0] LOCK_ERASED = 4'hF;

   localparam int IRQ_W       = 3;
   localparam int IRQ_ST_DENY = 0;
   localparam int IRQ_LD_DENY = 1;
   localparam int IRQ_DONE    = 2;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef enum logic [1:0] {
      OP_PAGE_LOAD,
      OP_PAGE_ERASE,
      OP_PAGE_WRITE
   } op_kind_e;

   typedef struct packed {
      logic              valid;
      op_kind_e          kind;
      logic [ADDR_W-1:0] target;
      logic [ADDR_W-1:0] pc;
   } store_req_s;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] target;
      logic [ADDR_W-1:0] pc;
   } load_req_s;

   typedef struct packed {
      logic              start;
      op_kind_e          kind;
      logic [ADDR_W-1:0] target;
   } flash_cmd_s;

endpackage

// *** prog_timer.sv ***
module prog_timer
   import flash_guard_pkg::*;
#(
   parameter int CYCLES = 1
) (
   // clock and reset
   input  wire logic CLK,
   input  wire logic SYS_RST,
   input  wire logic CE,
   // operation
   input  wire logic START,
   output logic      BUSY,
   output logic      DONE
);

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   logic [CNT_W-1:0] cnt_r;

   // counts the flash busy time, done is a single pulse at the end
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cnt_r <= '0;
         BUSY  <= 1'b0;
         DONE  <= 1'b0;
      end else if (CE) begin
         DONE <= 1'b0;
         if (START && !BUSY) begin
            cnt_r <= CNT_LOAD;
            BUSY  <= 1'b1;
         end else if (BUSY) begin
            cnt_r <= cnt_r - CNT_ONE;
            if (cnt_r == CNT_ONE) begin
               BUSY <= 1'b0;
               DONE <= 1'b1;
            end
         end
      end
   end

endmodule // prog_timer

// *** flash_self_program_guard.sv ***
// The placing of the registers and the Wishbone slave port were left to the implementer.
module flash_self_program_guard
   import flash_guard_pkg::*;
#(
   parameter int                OP_TIME_NS     = 4_000_000,
   parameter logic [ADDR_W-1:0] STALL_START    = 13'h1C00,
   parameter int                BOOT_MIN_WORDS = 128
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        CE,
   // wishbone slave
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [31:0] WB_DAT_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic        WB_WE_I,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // cpu core
   input  wire store_req_s  ST_REQ,
   input  wire load_req_s   LD_REQ,
   input  wire logic [ADDR_W-1:0] EXEC_PC,
   input  wire logic        VEC_IN_BOOT,
   output logic             ST_GRANT,
   output logic             ST_DENY,
   output logic             LD_GRANT,
   output logic             LD_DENY,
   output logic             CPU_HALT,
   output logic             CRS_READ_BLOCK,
   output logic             IRQ_INHIBIT,
   // fuses and external programming
   input  wire logic [1:0]  BOOT_SIZE_FUSES,
   input  wire logic        EXT_LOCK_WE,
   input  wire logic [3:0]  EXT_LOCK_VAL,
   input  wire logic        CHIP_ERASE,
   // flash macro and interrupt
   output flash_cmd_s       FLASH_CMD,
   output logic             IRQ
);

   localparam int OP_CYC_RAW = OP_TIME_NS / CLK_PERIOD_NS;
   localparam int OP_CYCLES  = (OP_CYC_RAW < 1) ? 1 : OP_CYC_RAW;
   localparam logic [ADDR_W:0] FLASH_WORDS = (ADDR_W+1)'(1) << ADDR_W;

   ////////////////////////////////////////////////////////////////////////////
   // section decoding

   logic [1:0]        fuse_s1, fuse_s2, fuse_s3;
   logic [1:0]        boot_size_r;
   logic [ADDR_W-1:0] boot_base_r;
   logic [3:0]        lock_r;
   logic              crs_busy_r;
   logic              op_busy_r;
   logic [IRQ_W-1:0]  irq_stat_r, irq_mask_r;

   function automatic logic [ADDR_W-1:0] boot_base(input logic [1:0] code);
      logic [ADDR_W:0] sz;
      logic [ADDR_W:0] base;
      sz   = (ADDR_W+1)'(BOOT_MIN_WORDS) << (BOOT_SIZE_TOP - code);
      base = FLASH_WORDS - sz;
      // a larger boot section is cut back to the stalling boundary
      if (base < {1'b0, STALL_START}) begin
         base = {1'b0, STALL_START};
      end
      boot_base = base[ADDR_W-1:0];
   endfunction

   function automatic logic in_boot(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
      in_boot = (a >= base);
   endfunction

   function automatic logic in_crs(input logic [ADDR_W-1:0] a);
      in_crs = (a < STALL_START);
   endfunction

   // fuse pins: three stages, taken once stages two and three agree
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         fuse_s1 <= BOOT_SIZE_RST;
         fuse_s2 <= BOOT_SIZE_RST;
         fuse_s3 <= BOOT_SIZE_RST;
      end else if (CE) begin
         fuse_s1 <= BOOT_SIZE_FUSES;
         fuse_s2 <= fuse_s1;
         fuse_s3 <= fuse_s2;
      end
   end

   // boundary is registered so the compare logic sees a stable base
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         boot_size_r <= BOOT_SIZE_RST;
         boot_base_r <= STALL_START;
      end else if (CE) begin
         if (fuse_s2 == fuse_s3) begin
            boot_size_r <= fuse_s3;
         end
         boot_base_r <= boot_base(boot_size_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // access checks

   logic [1:0] app_lock, boot_lock;
   logic       st_from_boot, st_tgt_boot, st_lock_ok, st_ok, st_start;
   logic       st_page_load;
   logic       ld_src_boot, ld_tgt_boot, ld_lock_ok, ld_ok;
   logic       op_done;

   assign app_lock  = lock_r[LOCK_APP_LSB +: LOCK_W];
   assign boot_lock = lock_r[LOCK_BOOT_LSB +: LOCK_W];

   // only the boot and application lock pairs are consulted; general lock modes play no part
   always_comb begin
      st_from_boot = in_boot(ST_REQ.pc, boot_base_r);
      st_tgt_boot  = in_boot(ST_REQ.target, boot_base_r);
      // store guard bit of the section that holds the target page
      st_lock_ok   = st_tgt_boot ? boot_lock[LOCK_LOW]
                                 : app_lock[LOCK_LOW];
      st_page_load = (ST_REQ.kind == OP_PAGE_LOAD);
      // from boot and while no operation is busy, page load always, erase or write only while the target's store guard bit is set; nothing from the application
      st_ok = ST_REQ.valid && st_from_boot && !op_busy_r
              && (st_page_load || st_lock_ok);
      st_start = st_ok && !st_page_load;
      ld_src_boot = in_boot(LD_REQ.pc, boot_base_r);
      ld_tgt_boot = in_boot(LD_REQ.target, boot_base_r);
      // a load within its own section is never locked
      ld_lock_ok = ld_tgt_boot ? (ld_src_boot || boot_lock[LOCK_HIGH])
                               : (!ld_src_boot || app_lock[LOCK_HIGH]);
      ld_ok = LD_REQ.valid && ld_lock_ok && !CPU_HALT
              && !(crs_busy_r && in_crs(LD_REQ.target));
   end

   ////////////////////////////////////////////////////////////////////////////
   // flash operation sequencing

   prog_timer #(
      .CYCLES (OP_CYCLES)
   ) u_timer (
      .CLK     (CLK),
      .SYS_RST (SYS_RST),
      .CE      (CE),
      .START   (st_start),
      .BUSY    (),
      .DONE    (op_done)
   );

   // answers to the core, one cycle after the request
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ST_GRANT <= 1'b0;
         ST_DENY  <= 1'b0;
         LD_GRANT <= 1'b0;
         LD_DENY  <= 1'b0;
      end else if (CE) begin
         ST_GRANT <= st_ok;
         ST_DENY  <= ST_REQ.valid && !st_ok;
         LD_GRANT <= ld_ok;
         LD_DENY  <= LD_REQ.valid && !ld_ok;
      end
   end

   // command to the flash macro, denied requests never reach it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         FLASH_CMD <= '0;
      end else if (CE) begin
         FLASH_CMD.start  <= st_ok;
         FLASH_CMD.kind   <= ST_REQ.kind;
         FLASH_CMD.target <= ST_REQ.target;
      end
   end

   // halt only when the erased or written page is in the stalling section
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         op_busy_r <= 1'b0;
         CPU_HALT  <= 1'b0;
      end else if (CE) begin
         if (st_start) begin
            op_busy_r <= 1'b1;
            CPU_HALT  <= !in_crs(ST_REQ.target);
         end else if (op_done) begin
            op_busy_r <= 1'b0;
            CPU_HALT  <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // section busy flag

   logic wb_wr, wb_rd;
   logic reen_wr;

   assign wb_wr   = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
   assign wb_rd   = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
   assign reen_wr = wb_wr && WB_SEL_I[0] && (WB_ADR_I == REG_CTRL)
                    && WB_DAT_I[CTRL_REEN];

   // set wins; re-enable is ignored while the flash is still busy
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         crs_busy_r <= 1'b0;
      end else if (CE) begin
         if (st_start) begin
            crs_busy_r <= 1'b1;
         end else if ((reen_wr && !op_busy_r) || (st_ok && st_page_load)) begin
            crs_busy_r <= 1'b0;
         end
      end
   end

   // block output mirrors the flag seen in the status register
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         CRS_READ_BLOCK <= 1'b0;
      end else if (CE) begin
         CRS_READ_BLOCK <= (st_start || crs_busy_r)
                           && !((reen_wr && !op_busy_r) && !st_start)
                           && !(st_ok && st_page_load);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock bits

   // bits can only go to programmed; chip erase or reset reopens them
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         lock_r <= LOCK_ERASED;
      end else if (CE) begin
         if (CHIP_ERASE) begin
            lock_r <= LOCK_ERASED;
         end else begin
            lock_r <= lock_r
                      & ((wb_wr && WB_SEL_I[0] && WB_ADR_I == REG_LOCK)
                         ? WB_DAT_I[3:0] : LOCK_ERASED)
                      & (EXT_LOCK_WE ? EXT_LOCK_VAL : LOCK_ERASED);
         end
      end
   end

   // mode 3 and 4 (load guard clear) mask interrupts that would cross over
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         IRQ_INHIBIT <= 1'b0;
      end else if (CE) begin
         IRQ_INHIBIT <=
            (!app_lock[LOCK_HIGH] && VEC_IN_BOOT
             && !in_boot(EXEC_PC, boot_base_r))
            || (!boot_lock[LOCK_HIGH] && !VEC_IN_BOOT
             && in_boot(EXEC_PC, boot_base_r));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask

   logic [IRQ_W-1:0] irq_evt, irq_clr;

   assign irq_evt = {op_done, LD_REQ.valid && !ld_ok, ST_REQ.valid && !st_ok};
   assign irq_clr = (wb_wr && WB_SEL_I[0] && WB_ADR_I == REG_IRQ_STAT)
                    ? WB_DAT_I[IRQ_W-1:0] : '0;

   // write one to clear, a new event in the same cycle is kept
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         IRQ        <= 1'b0;
      end else if (CE) begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
         if (wb_wr && WB_SEL_I[0] && WB_ADR_I == REG_IRQ_MASK) begin
            irq_mask_r <= WB_DAT_I[IRQ_W-1:0];
         end
         IRQ <= |(irq_stat_r & irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave, answers every address one cycle after the strobe

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end else if (CE) begin
         WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
         WB_DAT_O <= '0;
         if (wb_rd) begin
            case (WB_ADR_I)
               REG_STATUS: begin
                  WB_DAT_O[STAT_BUSY] <= crs_busy_r;
                  WB_DAT_O[STAT_HALT] <= CPU_HALT;
                  WB_DAT_O[STAT_OP]   <= op_busy_r;
               end
               REG_LOCK:     WB_DAT_O[3:0]       <= lock_r;
               REG_IRQ_STAT: WB_DAT_O[IRQ_W-1:0] <= irq_stat_r;
               REG_IRQ_MASK: WB_DAT_O[IRQ_W-1:0] <= irq_mask_r;
               default:      WB_DAT_O            <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_app_store;
      CE && ST_REQ.valid && !in_boot(ST_REQ.pc, boot_base_r);
   endsequence

   property p_app_store_refused;
      s_app_store |=> ST_DENY && !ST_GRANT && !FLASH_CMD.start;
   endproperty
   a_app_store_refused: assert property (p_app_store_refused)
      else $error("store from application section was not refused");

   property p_boot_store_boot_page;
      CE && ST_REQ.valid && in_boot(ST_REQ.pc, boot_base_r)
      && in_boot(ST_REQ.target, boot_base_r) && !op_busy_r
      && boot_lock[LOCK_LOW] |=> ST_GRANT;
   endproperty
   a_boot_store_boot_page: assert property (p_boot_store_boot_page)
      else $error("boot store to open boot page was refused");

   property p_boot_in_stall;
      boot_base_r >= STALL_START;
   endproperty
   a_boot_in_stall: assert property (p_boot_in_stall)
      else $error("boot section reaches into concurrent-read section");

   sequence s_stall_start;
      CE && st_start && !in_crs(ST_REQ.target);
   endsequence

   property p_stall_halts;
      s_stall_start |=> CPU_HALT && CRS_READ_BLOCK && op_busy_r;
   endproperty
   a_stall_halts: assert property (p_stall_halts)
      else $error("stalling section operation did not halt the cpu");

   property p_crs_runs;
      CE && st_start && in_crs(ST_REQ.target) |=> !CPU_HALT && CRS_READ_BLOCK;
   endproperty
   a_crs_runs: assert property (p_crs_runs)
      else $error("concurrent section operation halted the cpu");

   property p_crs_load_blocked;
      CE && LD_REQ.valid && crs_busy_r && in_crs(LD_REQ.target)
      |=> LD_DENY && !LD_GRANT;
   endproperty
   a_crs_load_blocked: assert property (p_crs_load_blocked)
      else $error("load from blocked section was granted");

   property p_busy_mirror;
      CRS_READ_BLOCK == crs_busy_r;
   endproperty
   a_busy_mirror: assert property (p_busy_mirror)
      else $error("block output differs from section busy flag");

   property p_lock_only_programs;
      !CHIP_ERASE |=> ((lock_r & ~$past(lock_r)) == 4'h0);
   endproperty
   a_lock_only_programs: assert property (p_lock_only_programs)
      else $error("lock bit returned to unprogrammed without chip erase");

   property p_app_load_boot;
      CE && LD_REQ.valid && !in_boot(LD_REQ.pc, boot_base_r)
      && in_boot(LD_REQ.target, boot_base_r) && !boot_lock[LOCK_HIGH]
      |=> LD_DENY;
   endproperty
   a_app_load_boot: assert property (p_app_load_boot)
      else $error("application load from locked boot section granted");

   property p_reenable;
      CE && reen_wr && !op_busy_r && !st_start |=> !crs_busy_r;
   endproperty
   a_reenable: assert property (p_reenable)
      else $error("read re-enable did not clear section busy");

   property p_refused_quiet;
      CE && ST_REQ.valid && !st_ok && !CHIP_ERASE && !EXT_LOCK_WE && !wb_wr
      |=> $stable(lock_r) && !$rose(crs_busy_r);
   endproperty
   a_refused_quiet: assert property (p_refused_quiet)
      else $error("refused store disturbed locks or busy flag");

endmodule // flash_self_program_guard

// *** cpu_core_model.sv ***
module cpu_core_model
   import flash_guard_pkg::*;
(
   // clock
   input  wire logic         clk,
   // requests toward the guard
   output store_req_s        st_req,
   output load_req_s         ld_req,
   output logic [ADDR_W-1:0] exec_pc,
   output logic              vec_in_boot
);
   timeunit 1ns;
   timeprecision 1ns;

   // vectors kept in the boot section so no fetch hits a blocked section
   initial begin
      st_req = '0;
      ld_req = '0;
      exec_pc = '0;
      vec_in_boot = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one-cycle requests; idle lines carry inverted target and pc, the store kind stays as it was
   task automatic store(input op_kind_e k, input logic [ADDR_W-1:0] t,
                        input logic [ADDR_W-1:0] pc);
      @(posedge clk);
      st_req <= '{1'b1, k, t, pc};
      exec_pc <= pc;
      @(posedge clk);
      st_req <= '{1'b0, k, ~t, ~pc};
   endtask

   task automatic load(input logic [ADDR_W-1:0] t,
                       input logic [ADDR_W-1:0] pc);
      @(posedge clk);
      ld_req <= '{1'b1, t, pc};
      exec_pc <= pc;
      @(posedge clk);
      ld_req <= '{1'b0, ~t, ~pc};
   endtask

   // moves the vector table; only safe while no concurrent-read page is busy
   task automatic vectors(input logic in_boot);
      @(posedge clk);
      vec_in_boot <= in_boot;
   endtask
endmodule // cpu_core_model

// *** testbench.sv ***
module testbench
   import flash_guard_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [1:0] G = 2'b10;
   localparam logic [1:0] D = 2'b01;
   localparam logic [ADDR_W-1:0] STALL_START = 13'h1C00;

   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [1:0] fuses = 2'h0;
   logic ext_we = 1'b0, chip_erase = 1'b0;
   logic [3:0] ext_val = 4'hF;
   store_req_s st_req;
   load_req_s ld_req;
   logic [ADDR_W-1:0] exec_pc, t;
   logic vib, st_g, st_d, ld_g, ld_d, halt, crs_blk, inhibit, irq, ack;
   logic [31:0] dat_o;
   flash_cmd_s cmd;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 32'h0000_A7C6;
   logic [1:0] st_q[$], ld_q[$];
   logic [31:0] rd_q[$];
   flash_cmd_s cmd_q[$];
   logic [1:0] blk_q[$];

   always #(CLK_PERIOD_NS / 2) CLK = ~CLK;

   flash_self_program_guard #(
      .OP_TIME_NS  (200),
      .STALL_START (STALL_START)
   ) dut (
      .CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1),
      .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'hF), .WB_WE_I(we),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .ST_REQ(st_req), .LD_REQ(ld_req), .EXEC_PC(exec_pc),
      .VEC_IN_BOOT(vib), .ST_GRANT(st_g), .ST_DENY(st_d), .LD_GRANT(ld_g),
      .LD_DENY(ld_d), .CPU_HALT(halt), .CRS_READ_BLOCK(crs_blk),
      .IRQ_INHIBIT(inhibit), .BOOT_SIZE_FUSES(fuses),
      .EXT_LOCK_WE(ext_we), .EXT_LOCK_VAL(ext_val),
      .CHIP_ERASE(chip_erase), .FLASH_CMD(cmd), .IRQ(irq));

   cpu_core_model core (.clk(CLK), .st_req(st_req), .ld_req(ld_req),
                        .exec_pc(exec_pc), .vec_in_boot(vib));

   ////////////////////////////////////////////////////////////////////////////
   // compare tasks and the single exit
   task automatic cmp_resp(string n, logic [1:0] e, logic [1:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %b got %b", n, e, g);
      end
   endtask

   task automatic cmp_data(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic test_done();
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // monitor: an empty queue yields x, so a surplus answer fails
   always @(posedge CLK) begin
      if ((st_g | st_d) === 1'b1) begin
         cmp_resp("store", st_q.size() ? st_q.pop_front() : 2'bxx,
                  {st_g, st_d});
         cmp_data("flash cmd", cmd_q.size() ? cmd_q.pop_front() : 'x,
                  cmd);
      end
      // halt and block rise together with the grant
      if (st_g === 1'b1)
         cmp_resp("halt block", blk_q.size() ? blk_q.pop_front() : 2'bxx,
                  {halt, crs_blk});
      if ((ld_g | ld_d) === 1'b1)
         cmp_resp("load", ld_q.size() ? ld_q.pop_front() : 2'bxx, {ld_g, ld_d});
      if (ack === 1'b1 && we === 1'b0)
         cmp_data("read", rd_q.size() ? rd_q.pop_front() : 'x, dat_o);
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus master and request helpers
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // no cycle count assumed, a hang is left to the watchdog
      do begin
         @(posedge CLK);
      end while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic st(op_kind_e k, logic [12:0] tg, logic [12:0] pc,
                     logic [1:0] e);
      st_q.push_back(e);
      cmd_q.push_back(flash_cmd_s'({e == G, k, tg}));
      // erase or write blocks reads, halting only in the stalling section
      if (e == G)
         blk_q.push_back({k != OP_PAGE_LOAD && tg >= STALL_START,
                          k != OP_PAGE_LOAD});
      core.store(k, tg, pc);
   endtask

   task automatic ld(logic [12:0] tg, logic [12:0] pc, logic [1:0] e);
      ld_q.push_back(e);
      core.load(tg, pc);
   endtask

   // watchdog, far beyond the fewer than two hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge CLK);
      mismatches++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd(REG_LOCK, 32'h0000_000F);
      rd(REG_STATUS, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      repeat (6) @(posedge CLK);
      st(OP_PAGE_LOAD, 13'h0040, 13'h0100, D);
      st(OP_PAGE_LOAD, 13'h0040, 13'h1C10, G);
      fuses <= 2'h3;
      repeat (8) @(posedge CLK);
      st(OP_PAGE_LOAD, 13'h0040, 13'h1C10, D);
      st(OP_PAGE_LOAD, 13'h0040, 13'h1F90, G);
      fuses <= 2'h0;
      repeat (8) @(posedge CLK);
      t = 13'($random(seed)) & 13'h0FFF;
      st(OP_PAGE_ERASE, t, 13'h1C10, G);
      st(OP_PAGE_ERASE, t, 13'h1C10, D); // busy op refuses a second one
      ld(13'h0200, 13'h1C10, D);
      ld(13'h1D00, 13'h1C10, G);
      rd(REG_STATUS, 32'h0000_0005);
      repeat (12) @(posedge CLK);
      rd(REG_STATUS, 32'h0000_0001);
      wb(1'b1, REG_CTRL, 32'h0000_0001);
      rd(REG_STATUS, 32'h0000_0000);
      rd(REG_IRQ_STAT, 32'h0000_0007);
      wb(1'b1, REG_IRQ_MASK, 32'h0000_0004);
      repeat (2) @(posedge CLK);
      cmp_resp("irq", 2'b01, {1'b0, irq});
      wb(1'b1, REG_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge CLK);
      cmp_resp("irq", 2'b00, {1'b0, irq});
      st(OP_PAGE_WRITE, 13'h1E00, 13'h1C10, G);
      ld(13'h1D00, 13'h1C10, D);
      rd(REG_STATUS, 32'h0000_0007);
      repeat (12) @(posedge CLK);
      rd(REG_STATUS, 32'h0000_0001);
      st(OP_PAGE_LOAD, 13'h0040, 13'h1C10, G);
      rd(REG_STATUS, 32'h0000_0000);
      wb(1'b1, REG_LOCK, 32'h0000_000C);
      rd(REG_LOCK, 32'h0000_000C);
      st(OP_PAGE_ERASE, t, 13'h1C10, D);
      ld(13'h0100, 13'h1C10, D);
      rd(REG_STATUS, 32'h0000_0000);
      ld(13'h0100, 13'h0100, G);
      repeat (3) @(posedge CLK);
      cmp_resp("inhibit", 2'b01, {1'b0, inhibit});
      ext_val <= 4'h7;
      ext_we <= 1'b1;
      @(posedge CLK);
      ext_we <= 1'b0;
      rd(REG_LOCK, 32'h0000_0004);
      ld(13'h1C80, 13'h0100, D);
      st(OP_PAGE_ERASE, 13'h1C80, 13'h1C10, G);
      core.vectors(1'b0);
      repeat (2) @(posedge CLK);
      cmp_resp("inhibit", 2'b01, {1'b0, inhibit});
      wb(1'b1, REG_LOCK, 32'h0000_000F);
      rd(REG_LOCK, 32'h0000_0004);
      chip_erase <= 1'b1;
      @(posedge CLK);
      chip_erase <= 1'b0;
      rd(REG_LOCK, 32'h0000_000F);
      cmp_resp("inhibit", 2'b00, {1'b0, inhibit});
      repeat (14) @(posedge CLK);
      test_done();
   end
endmodule // testbench
